// *** design/srb_bank.sv ***
// Serial-loaded write-only register bank with power management
//
// How it works
// R1 - Frame is 24 bits, one register word
// R2 - Low 4 bits address, upper 20 data
// R3 - Unused data bits are ignored
// R4 - Master sends data MSB first, address last
// R5 - Shift data on serial rising edge, select low
// R6 - Select rising commits data to addressed register
// R7 - Decode addresses 0-5 and 7
// R8 - Registers power up to their defaults
// R9 - RF main divider uses low 18 bits
// R10 - RF PLL runs from RF divider pair
// R11 - IF PLL runs from IF divider pair
// R12 - Soft power-down keeps serial interface alive
// R13 - Power-down pin stops everything, serial too
// R14 - Either power-down loses register contents
// R15 - Standby keeps registers, stops functions
// R16 - Test register best left at default
// R17 - Soft power-down bit 0 restores defaults
// R18 - Standby bit 2 stops all but registers
// R19 - Master should write unused bits as zero
// R20 - Unknown address frames are discarded
// R21 - Extra bits: last 24 form the frame
`timescale 1ns/1ps
`include "srb_bank_cfg.svh"

module srb_bank
    import srb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        serial_clk,
    input  wire logic        select_n,
    input  wire logic        serial_din,
    input  wire logic        powerdown_pin_n,
    output logic [17:0]      rf_main_divide,
    output logic [12:0]      rf_reference_divide,
    output logic [13:0]      if_main_divide,
    output logic [10:0]      if_reference_divide,
    output logic [15:0]      operation_control,
    output logic [15:0]      pll_and_input_setup,
    output logic [7:0]       factory_test_control,
    output srb_pwr_e         power_state,
    output logic             core_enable,
    output logic             rf_pll_enable,
    output logic             if_pll_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain

    logic [`SRB_FRAME_BITS-1:0] shift_reg;
    logic [`SRB_CNT_BITS-1:0]   bit_cnt_reg;
    logic                       idle_reg;

    // Frame start marker, set while select is high; the serial clock may stop between frames
    always_ff @(posedge serial_clk or posedge select_n or posedge sys_rst)
    begin
        if (select_n || sys_rst)
            idle_reg <= 1'b1;
        else
            idle_reg <= 1'b0;
    end

    // Shift in MSB first; older bits fall off the top [R5] [R4] [R21]
    always_ff @(posedge serial_clk or posedge sys_rst)
    begin
        if (sys_rst)
            shift_reg <= '0;
        else if (!select_n)
            shift_reg <= {shift_reg[`SRB_FRAME_BITS-2:0], serial_din};
    end

    // Bit count, saturating at a full frame [R1]
    always_ff @(posedge serial_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bit_cnt_reg <= '0;
        else if (!select_n)
        begin
            if (idle_reg)
                bit_cnt_reg <= 5'h01;
            else if (bit_cnt_reg != 5'(`SRB_FRAME_BITS))
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers into the system clock

    logic sel_s1, sel_s2, sel_s3, sel_stable;
    logic pin_s1, pin_s2, pin_s3, pin_stable;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sel_s1     <= 1'b1;
            sel_s2     <= 1'b1;
            sel_s3     <= 1'b1;
            sel_stable <= 1'b1;
            pin_s1     <= 1'b0;
            pin_s2     <= 1'b0;
            pin_s3     <= 1'b0;
            pin_stable <= 1'b0;
        end
        else
        begin
            sel_s1 <= select_n;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
            pin_s1 <= powerdown_pin_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (sel_s2 == sel_s3)
                sel_stable <= sel_s3;
            if (pin_s2 == pin_s3)
                pin_stable <= pin_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame commit

    logic                      sel_rise;
    logic                      frame_full;
    logic                      commit;
    logic [`SRB_ADDR_BITS-1:0] frame_addr;
    srb_data_t                 frame_data;

    // Shift register and count are quiet here: select is high, so no serial edge moves them
    assign sel_rise   = !sel_stable && sel_s2 && sel_s3;                       // [R6]
    assign frame_full = (bit_cnt_reg == 5'(`SRB_FRAME_BITS));                  // [R1]
    assign commit     = sel_rise && frame_full && pin_stable;                  // [R13]
    assign frame_addr = shift_reg[`SRB_ADDR_BITS-1:0];                         // [R2]
    assign frame_data = shift_reg[`SRB_FRAME_BITS-1:`SRB_ADDR_BITS];           // [R2]

    logic soft_pd_write;
    logic soft_pd_reg;

    assign soft_pd_write = commit && (frame_addr == `SRB_ADDR_OPERATION_CONTROL)
                           && !frame_data[`SRB_BIT_SOFT_PD];                   // [R17]

    ////////////////////////////////////////////////////////////////////////
    // Register bank

    // Pin power-down or soft power-down wipes the bank [R14] [R8]
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rf_main_divide       <= `SRB_RST_RF_MAIN;
            rf_reference_divide  <= `SRB_RST_RF_REF;
            if_main_divide       <= `SRB_RST_IF_MAIN;
            if_reference_divide  <= `SRB_RST_IF_REF;
            operation_control    <= `SRB_RST_OPERATION_CONTROL;
            pll_and_input_setup  <= `SRB_RST_SETUP;
            factory_test_control <= `SRB_RST_TEST;
        end
        else if (!pin_stable || soft_pd_write)                                 // [R14] [R17]
        begin
            rf_main_divide       <= `SRB_RST_RF_MAIN;
            rf_reference_divide  <= `SRB_RST_RF_REF;
            if_main_divide       <= `SRB_RST_IF_MAIN;
            if_reference_divide  <= `SRB_RST_IF_REF;
            operation_control    <= `SRB_RST_OPERATION_CONTROL;
            pll_and_input_setup  <= `SRB_RST_SETUP;
            factory_test_control <= `SRB_RST_TEST;
        end
        else if (commit)
        begin
            // Only the used low bits are stored [R3] [R9]; unknown addresses fall through [R20]
            case (frame_addr)                                                  // [R7]
                `SRB_ADDR_RF_MAIN: rf_main_divide       <= frame_data[17:0];
                `SRB_ADDR_RF_REF:  rf_reference_divide  <= frame_data[12:0];
                `SRB_ADDR_IF_MAIN: if_main_divide       <= frame_data[13:0];
                `SRB_ADDR_IF_REF:  if_reference_divide  <= frame_data[10:0];
                `SRB_ADDR_OPERATION_CONTROL:  operation_control    <= frame_data[15:0];
                `SRB_ADDR_SETUP:   pll_and_input_setup  <= frame_data[15:0];
                `SRB_ADDR_TEST:    factory_test_control <= frame_data[7:0];
                default:           ;
            endcase
        end
    end

    // Soft power-down holds until an operation control write with the bit set or a pin power-down [R12]
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            soft_pd_reg <= 1'b0;
        else if (!pin_stable)
            soft_pd_reg <= 1'b0;
        else if (commit && frame_addr == `SRB_ADDR_OPERATION_CONTROL)
            soft_pd_reg <= !frame_data[`SRB_BIT_SOFT_PD];
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state and enables

    srb_pwr_e pwr_next;
    logic     run_next;

    // Pin beats soft bit beats standby
    always_comb
    begin
        if (!pin_stable)
            pwr_next = SRB_PWR_PIN_DOWN;                                       // [R13]
        else if (soft_pd_reg)
            pwr_next = SRB_PWR_SOFT_DOWN;                                      // [R12]
        else if (!operation_control[`SRB_BIT_STANDBY])
            pwr_next = SRB_PWR_STANDBY;                                        // [R15] [R18]
        else
            pwr_next = SRB_PWR_RUN;
    end

    always_comb
    begin
        case (pwr_next)
            SRB_PWR_RUN: run_next = 1'b1;
            default:     run_next = 1'b0;
        endcase
    end

    // Enables are registered so every output comes from a flop
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_state   <= SRB_PWR_PIN_DOWN;
            core_enable   <= 1'b0;
            rf_pll_enable <= 1'b0;
            if_pll_enable <= 1'b0;
        end
        else
        begin
            power_state   <= pwr_next;
            core_enable   <= run_next;
            rf_pll_enable <= run_next && pll_and_input_setup[`SRB_BIT_RF_PLL_ON];  // [R10]
            if_pll_enable <= run_next && pll_and_input_setup[`SRB_BIT_IF_PLL_ON];  // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Helper: standby bit of the waking write, seen one cycle later
    logic frame_data_past_standby_bit;
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            frame_data_past_standby_bit <= 1'b0;
        else
            frame_data_past_standby_bit <= frame_data[`SRB_BIT_STANDBY];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_SHORT_FRAME: assert property ( // [R1]
        sel_rise && !frame_full |=> $stable(rf_main_divide) && $stable(operation_control))
        else $error("short frame changed a register");

    AST_RF_MAIN_WRITE: assert property ( // [R9]
        commit && frame_addr == `SRB_ADDR_RF_MAIN |=> rf_main_divide == $past(frame_data[17:0]))
        else $error("rf main divider not loaded from frame");

    AST_TEST_WRITE: assert property ( // [R7]
        commit && frame_addr == `SRB_ADDR_TEST
        |=> factory_test_control == $past(frame_data[7:0]) && $stable(pll_and_input_setup))
        else $error("test register write went astray");

    AST_BAD_ADDR: assert property ( // [R20]
        commit && (frame_addr == 4'h6 || frame_addr[3])
        |=> $stable(rf_main_divide) && $stable(operation_control) && $stable(factory_test_control))
        else $error("unmapped frame changed a register");

    AST_PIN_DOWN: assert property ( // [R13]
        !pin_stable |=> operation_control == `SRB_RST_OPERATION_CONTROL && power_state == SRB_PWR_PIN_DOWN && !core_enable)
        else $error("pin power-down did not clear bank");

    AST_SOFT_PD: assert property ( // [R17]
        soft_pd_write |=> rf_main_divide == `SRB_RST_RF_MAIN && soft_pd_reg ##1 power_state == SRB_PWR_SOFT_DOWN)
        else $error("soft power-down did not restore defaults");

    AST_SOFT_WAKE: assert property ( // [R12]
        soft_pd_reg && commit && frame_addr == `SRB_ADDR_OPERATION_CONTROL && frame_data[`SRB_BIT_SOFT_PD]
        |=> ##1 core_enable == frame_data_past_standby_bit)
        else $error("serial write did not wake from soft power-down");

    AST_STANDBY: assert property ( // [R15]
        commit && frame_addr == `SRB_ADDR_OPERATION_CONTROL && frame_data[`SRB_BIT_SOFT_PD] && !frame_data[`SRB_BIT_STANDBY]
        |=> operation_control == $past(frame_data[15:0]) ##1 power_state == SRB_PWR_STANDBY && !core_enable)
        else $error("standby lost registers or left core on");

    AST_PLL_GATE: assert property ( // [R10]
        rf_pll_enable || if_pll_enable |-> core_enable)
        else $error("pll enabled while core is off");

    // Register loads: each decoded address keeps only its own low bits
    AST_RF_REF_WRITE: assert property ( // [R3]
        commit && frame_addr == `SRB_ADDR_RF_REF |=> rf_reference_divide == $past(frame_data[12:0]))
        else $error("rf reference divider not loaded from frame");

    AST_IF_MAIN_WRITE: assert property ( // [R11]
        commit && frame_addr == `SRB_ADDR_IF_MAIN |=> if_main_divide == $past(frame_data[13:0]))
        else $error("if main divider not loaded from frame");

    AST_IF_REF_WRITE: assert property ( // [R3]
        commit && frame_addr == `SRB_ADDR_IF_REF |=> if_reference_divide == $past(frame_data[10:0]))
        else $error("if reference divider not loaded from frame");

    AST_SETUP_WRITE: assert property ( // [R7]
        commit && frame_addr == `SRB_ADDR_SETUP |=> pll_and_input_setup == $past(frame_data[15:0]))
        else $error("setup register not loaded from frame");

    // Power conditions; the enable must never run ahead of the state it reports
    AST_RUN_ENABLE: assert property ( // [R15]
        core_enable == (power_state == SRB_PWR_RUN))
        else $error("core enable disagrees with power state");

    AST_PIN_BLOCKS: assert property ( // [R13]
        !pin_stable |-> !commit)
        else $error("frame committed while pin power-down held");

    AST_STANDBY_KEEP: assert property ( // [R18]
        power_state == SRB_PWR_STANDBY && pin_stable && !commit
        |=> $stable(rf_main_divide) && $stable(if_main_divide) && $stable(operation_control))
        else $error("standby changed register contents");

    AST_WAKE_CLEAR: assert property ( // [R12]
        commit && frame_addr == `SRB_ADDR_OPERATION_CONTROL && frame_data[`SRB_BIT_SOFT_PD] |=> !soft_pd_reg)
        else $error("soft power-down flag not cleared by wake write");

    AST_SOFT_HOLD: assert property ( // [R12]
        soft_pd_reg && pin_stable && !commit |=> soft_pd_reg)
        else $error("soft power-down flag dropped without a write");

endmodule

// *** design/srb_bank_cfg.svh ***
// Frame layout, offsets, field positions and reset values of the serial register bank
`ifndef SRB_BANK_CFG_SVH
`define SRB_BANK_CFG_SVH

// Frame layout
`define SRB_FRAME_BITS     24
`define SRB_ADDR_BITS      4
`define SRB_DATA_BITS      20
`define SRB_CNT_BITS       5

// Register addresses
`define SRB_ADDR_RF_MAIN   4'h0
`define SRB_ADDR_RF_REF    4'h1
`define SRB_ADDR_IF_MAIN   4'h2
`define SRB_ADDR_IF_REF    4'h3
`define SRB_ADDR_OPERATION_CONTROL    4'h4
`define SRB_ADDR_SETUP     4'h5
`define SRB_ADDR_TEST      4'h7

// Power-up values, at register width
`define SRB_RST_RF_MAIN    18'h2A037
`define SRB_RST_RF_REF     13'h07B0
`define SRB_RST_IF_MAIN    14'h1977
`define SRB_RST_IF_REF     11'h1EC
`define SRB_RST_OPERATION_CONTROL     16'h892F
`define SRB_RST_SETUP      16'hD03F
`define SRB_RST_TEST       8'h00

// Bit positions
`define SRB_BIT_SOFT_PD    0
`define SRB_BIT_STANDBY    2
`define SRB_BIT_RF_PLL_ON  14
`define SRB_BIT_IF_PLL_ON  15

`endif

// *** design/srb_pkg.sv ***
// Types shared by the serial register bank
package srb_pkg;

    // Power condition of the device core
    typedef enum logic [1:0] {
        SRB_PWR_RUN       = 2'b00,
        SRB_PWR_STANDBY   = 2'b01,
        SRB_PWR_SOFT_DOWN = 2'b10,
        SRB_PWR_PIN_DOWN  = 2'b11
    } srb_pwr_e;

    typedef logic [19:0] srb_data_t;

endpackage

// *** verification/srb_serial_master.sv ***
// Behavioural serial master that loads frames into the register bank
`timescale 1ns/1ps

module srb_serial_master
(
    output logic serial_clk,
    output logic select_n,
    output logic serial_din
);

    ////////////////////////////////////////////////////////////////////////////
    // Idle lines; the link clock stands still between frames
    initial
    begin
        serial_clk = 1'b0;
        select_n   = 1'b1;
        serial_din = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame of n bits, sent from word[n-1] down to word[0], 48 ns link period
    task automatic send(input logic [31:0] word, input int unsigned n);
        begin
            #7 select_n = 1'b0;                      // Odd offset keeps phase unrelated
            for (int i = n - 1; i >= 0; i--)
            begin
                serial_din = word[i];                // Data MSB first, address last
                #24 serial_clk = 1'b1;
                #24 serial_clk = 1'b0;
            end
            #24 select_n = 1'b1;
            serial_din = ~serial_din;                // Released line shows no stale value
        end
    endtask

endmodule

// *** verification/testbench.sv ***
// Self-checking testbench of the serial register bank
`timescale 1ns/1ps
`include "srb_bank_cfg.svh"

module testbench
    import srb_pkg::*;
;

    logic        clock = 1'b0;
    logic        sys_rst;
    logic        powerdown_pin_n;
    logic        serial_clk;
    logic        select_n;
    logic        serial_din;
    logic [17:0] rf_main_divide;
    logic [12:0] rf_reference_divide;
    logic [13:0] if_main_divide;
    logic [10:0] if_reference_divide;
    logic [15:0] operation_control;
    logic [15:0] pll_and_input_setup;
    logic [7:0]  factory_test_control;
    srb_pwr_e    power_state;
    logic        core_enable;
    logic        rf_pll_enable;
    logic        if_pll_enable;
    logic [19:0] exp_r [0:7];
    logic        pin_dn;
    logic        soft_dn;
    int          error_cnt;
    int          n_compared;
    logic [3:0]  wmask_list [3] = '{4'h6, 4'h8, 4'hF};  // Undecoded, both ends of the unused range

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz system clock
    always #12.5 clock = ~clock;

    srb_serial_master i_master
    (
        .serial_clk (serial_clk),
        .select_n   (select_n),
        .serial_din (serial_din)
    );

    srb_bank i_dut
    (
        .clock                (clock),
        .sys_rst              (sys_rst),
        .serial_clk           (serial_clk),
        .select_n             (select_n),
        .serial_din           (serial_din),
        .powerdown_pin_n      (powerdown_pin_n),
        .rf_main_divide       (rf_main_divide),
        .rf_reference_divide  (rf_reference_divide),
        .if_main_divide       (if_main_divide),
        .if_reference_divide  (if_reference_divide),
        .operation_control    (operation_control),
        .pll_and_input_setup  (pll_and_input_setup),
        .factory_test_control (factory_test_control),
        .power_state          (power_state),
        .core_enable          (core_enable),
        .rf_pll_enable        (rf_pll_enable),
        .if_pll_enable        (if_pll_enable)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Expected model helpers
    function automatic logic [19:0] wmask(input logic [3:0] a);
        case (a)
            `SRB_ADDR_RF_MAIN: return 20'h3FFFF;
            `SRB_ADDR_RF_REF:  return 20'h01FFF;
            `SRB_ADDR_IF_MAIN: return 20'h03FFF;
            `SRB_ADDR_IF_REF:  return 20'h007FF;
            `SRB_ADDR_OPERATION_CONTROL:  return 20'h0FFFF;
            `SRB_ADDR_SETUP:   return 20'h0FFFF;
            `SRB_ADDR_TEST:    return 20'h000FF;
            default:           return 20'h00000;   // Undecoded address
        endcase
    endfunction

    task automatic set_dflt;
        begin
            exp_r[0] = 20'(`SRB_RST_RF_MAIN);
            exp_r[1] = 20'(`SRB_RST_RF_REF);
            exp_r[2] = 20'(`SRB_RST_IF_MAIN);
            exp_r[3] = 20'(`SRB_RST_IF_REF);
            exp_r[4] = 20'(`SRB_RST_OPERATION_CONTROL);
            exp_r[5] = 20'(`SRB_RST_SETUP);
            exp_r[7] = 20'(`SRB_RST_TEST);
        end
    endtask

    task automatic check(input string nm, input logic [19:0] exp, input logic [19:0] got);
        begin
            n_compared++;
            if (got !== exp)
            begin
                error_cnt++;
                $display("ERROR %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Compare every output against the expected bank and power condition
    task automatic check_bank;
        srb_pwr_e ps;
        logic     run;
        begin
            @(negedge clock);                          // Outputs settled mid-cycle
            ps = pin_dn ? SRB_PWR_PIN_DOWN : soft_dn ? SRB_PWR_SOFT_DOWN :
                 exp_r[4][`SRB_BIT_STANDBY] ? SRB_PWR_RUN : SRB_PWR_STANDBY;
            run = (ps == SRB_PWR_RUN);
            check("rf_main_divide", exp_r[0], 20'(rf_main_divide));
            check("rf_reference_divide", exp_r[1], 20'(rf_reference_divide));
            check("if_main_divide", exp_r[2], 20'(if_main_divide));
            check("if_reference_divide", exp_r[3], 20'(if_reference_divide));
            check("operation_control", exp_r[4], 20'(operation_control));
            check("pll_and_input_setup", exp_r[5], 20'(pll_and_input_setup));
            check("factory_test_control", exp_r[7], 20'(factory_test_control));
            check("power_state", 20'(ps), 20'(power_state));
            check("core_enable", 20'(run), 20'(core_enable));
            check("rf_pll_enable", 20'(run & exp_r[5][`SRB_BIT_RF_PLL_ON]), 20'(rf_pll_enable));
            check("if_pll_enable", 20'(run & exp_r[5][`SRB_BIT_IF_PLL_ON]), 20'(if_pll_enable));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // One 24-bit register write; the commit lands within a few system clocks
    task automatic write_reg(input logic [3:0] a, input logic [19:0] d);
        begin
            i_master.send({8'h00, d, a}, 24);
            if (!pin_dn && wmask(a) != 20'h00000)
            begin
                if (a == `SRB_ADDR_OPERATION_CONTROL && !d[`SRB_BIT_SOFT_PD])
                begin
                    set_dflt();
                    soft_dn = 1'b1;
                end
                else
                begin
                    exp_r[a] = d & wmask(a);
                    if (a == `SRB_ADDR_OPERATION_CONTROL)
                        soft_dn = 1'b0;
                end
            end
            repeat (6) @(posedge clock);
        end
    endtask

    task automatic test_done;
        begin
            $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, well above the length of the whole sequence
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst         = 1'b1;
        powerdown_pin_n = 1'b1;
        pin_dn          = 1'b0;
        soft_dn         = 1'b0;
        error_cnt       = 0;
        n_compared      = 0;
        set_dflt();
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        check_bank();
        // All ones into every decoded address, upper bits must be dropped
        for (int i = 0; i < 8; i++)
            if (i != 6)
                write_reg(4'(i), 20'hFFFFF);
        check_bank();
        write_reg(`SRB_ADDR_RF_MAIN, 20'h15A5A);
        // Undecoded addresses leave the bank alone
        foreach (wmask_list[k])
            write_reg(wmask_list[k], 20'h00000);
        // Short frame refused, long frame keeps its last 24 bits
        i_master.send({8'h00, 20'h12345, `SRB_ADDR_RF_MAIN}, 23);
        repeat (6) @(posedge clock);
        check_bank();
        i_master.send({6'h00, 2'b11, 20'h00ABC, `SRB_ADDR_RF_REF}, 26);
        exp_r[1] = 20'h00ABC;
        repeat (6) @(posedge clock);
        check_bank();
        // Standby keeps the registers, stops the core
        write_reg(`SRB_ADDR_OPERATION_CONTROL, 20'h0892B);
        check_bank();
        write_reg(`SRB_ADDR_OPERATION_CONTROL, 20'h0892F);
        check_bank();
        // Soft power-down restores defaults, serial still wakes it
        write_reg(`SRB_ADDR_OPERATION_CONTROL, 20'h0892E);
        check_bank();
        write_reg(`SRB_ADDR_OPERATION_CONTROL, 20'h0892D);
        check_bank();
        write_reg(`SRB_ADDR_SETUP, 20'h0803F);
        write_reg(`SRB_ADDR_IF_MAIN, 20'h01234);
        check_bank();
        // Pin power-down clears the bank and blocks the serial port
        @(posedge clock);
        powerdown_pin_n <= 1'b0;
        pin_dn = 1'b1;
        soft_dn = 1'b0;
        set_dflt();
        repeat (8) @(posedge clock);
        check_bank();
        write_reg(`SRB_ADDR_IF_REF, 20'h00055);
        powerdown_pin_n <= 1'b0;
        @(posedge clock);
        powerdown_pin_n <= 1'b1;
        pin_dn = 1'b0;
        repeat (8) @(posedge clock);
        check_bank();
        write_reg(`SRB_ADDR_TEST, 20'h00000);
        check_bank();
        test_done();
    end

endmodule
